// ---- verilog/msp_top.sv ----
// Multibuffer serial port: buffer-driven controller/target shift engine
`timescale 1ns/1ps
module msp_top
  import msp_pkg::*;
(
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire logic [31:0]                    global_control_reg,
  input  wire logic [FMT_SETS-1:0][31:0]      word_format_reg,
  input  wire logic [15:0]                    cs_delay_reg,
  input  wire logic [ENTRY_AW-1:0]            group_start,
  input  wire logic [ENTRY_AW-1:0]            group_end,
  input  wire logic                           group_trigger,
  output logic                                busy,
  output logic                                group_done,
  output logic [ENTRY_AW-1:0]                 active_entry,
  input  wire logic                           host_en,
  input  wire logic                           host_we,
  input  wire logic [RAM_AW-1:0]              host_addr,
  input  wire logic [DW-1:0]                  host_wdata,
  output logic [DW-1:0]                       host_rdata,
  input  wire logic                           shift_clock_pin_i,
  output logic                                shift_clock_pin_o,
  output logic                                shift_clock_pin_oe,
  input  wire logic                           controller_out_line_i,
  output logic                                controller_out_line_o,
  output logic                                controller_out_line_oe,
  input  wire logic                           controller_in_line_i,
  output logic                                controller_in_line_o,
  output logic                                controller_in_line_oe,
  input  wire logic                           chip_select_n_i,
  output logic                                chip_select_n_o,
  output logic                                chip_select_n_oe,
  input  wire logic [PINS-1:0]                gpio_sel,
  input  wire logic [PINS-1:0]                gpio_out,
  input  wire logic [PINS-1:0]                gpio_oe,
  output logic [PINS-1:0]                     gpio_in
);
  // ----------------------------------------
  // Buffer memory
  // ----------------------------------------
  msp_mem_if #(.AW(RAM_AW), .DW(DW)) mif ();

  msp_buf_ram #(.DEPTH(RAM_WORDS), .WIDTH(DW)) u_ram (
    .clock (clock),
    .m     (mif.mem)
  );

  assign mif.a_en    = host_en;
  assign mif.a_we    = host_we;
  assign mif.a_addr  = host_addr;
  assign mif.a_wdata = host_wdata;
  assign host_rdata  = mif.a_rdata;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PINS-1:0] pin_i, pin_o, pin_oe, fn_o, fn_oe, s1_q, s2_q, s3_q;

  assign pin_i = {chip_select_n_i, controller_in_line_i, controller_out_line_i,
                  shift_clock_pin_i};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      s3_q <= PIN_IDLE;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign gpio_in = s2_q;

  // ----------------------------------------
  // Engine state
  // ----------------------------------------
  msp_state_t          state_q, state_d;
  logic [ENTRY_AW-1:0] ptr_q, ptr_d;
  logic [DW-1:0]       ctl_q, ctl_d, tx_sr_q, tx_sr_d, rx_sr_q, rx_sr_d;
  logic [4:0]          len_q, len_d;
  logic [FMT_PS_W-1:0] ps_q, ps_d;
  logic                pha_q, pha_d, pol_q, pol_d, hold_q, hold_d;
  logic [9:0]          cnt_q, cnt_d;
  logic [5:0]          edge_q, edge_d;
  logic                clk_q, clk_d, cs_q, cs_d, abort_q, abort_d, done_q, done_d;

  logic                ctrl, cs_act, cs_rise, pin_edge, edge_ev, leading, din;
  logic [31:0]         fmt;
  logic [4:0]          len_new;
  logic [8:0]          per_cur, half_lo, half_hi, half_new;
  logic [9:0]          lead_len, lag_len;
  logic [5:0]          edge_total;
  logic [DW-1:0]       rx_mask;

  function automatic logic [8:0] period_of(input logic [FMT_PS_W-1:0] ps);
    logic [8:0] p;
    p = (ps == '0) ? PS0_PERIOD : ({1'b0, ps} + 9'h001);
    return (p < MIN_PERIOD_CYC) ? MIN_PERIOD_CYC : p;
  endfunction : period_of

  assign ctrl     = global_control_reg[GCR_CTRL];
  assign cs_act   = ~s2_q[PIN_CS];
  assign cs_rise  = cs_act & s3_q[PIN_CS];
  assign pin_edge = s2_q[PIN_CLK] ^ s3_q[PIN_CLK];
  assign din      = ctrl ? s2_q[PIN_SOMI] : s2_q[PIN_SIMO];
  assign fmt      = word_format_reg[ctl_q[CTL_FSEL_LSB +: CTL_FSEL_W]];

  always_comb begin
    len_new = fmt[FMT_LEN_LSB +: FMT_LEN_W];
    if (len_new < LEN_MIN) begin
      len_new = LEN_MIN;
    end else if (len_new > LEN_MAX) begin
      len_new = LEN_MAX;
    end
  end

  // Odd periods cannot split evenly; the level after the leading edge (high only when pol is 0) gets the shorter half
  assign per_cur    = period_of(ps_q);
  assign half_lo    = per_cur >> 1;
  assign half_hi    = per_cur - half_lo;
  assign half_new   = period_of(fmt[FMT_PS_LSB +: FMT_PS_W]) >> 1;
  assign edge_total = {len_q, 1'b0};
  assign leading    = ~edge_q[0];
  assign rx_mask    = 16'hFFFF >> (5'h10 - len_q);

  always_comb begin
    lead_len = {2'h0, cs_delay_reg[DLY_C2T_LSB +: DLY_W]} + C2T_BASE;
    if (fmt[FMT_PHA]) begin
      lead_len = lead_len + {1'b0, half_new};
      if (fmt[FMT_POL] && ctl_q[CTL_HOLD]) begin
        lead_len = lead_len + HOLD_EXTRA;
      end
    end else if (ctl_q[CTL_HOLD]) begin
      lead_len = lead_len + HOLD_EXTRA;
    end
    lag_len = {2'h0, cs_delay_reg[DLY_T2C_LSB +: DLY_W]} + T2C_BASE;
    if (!pha_q) begin
      lag_len = lag_len + {1'b0, half_lo};
    end
  end

  always_comb begin
    state_d = state_q;
    ptr_d   = ptr_q;
    ctl_d   = ctl_q;
    tx_sr_d = tx_sr_q;
    rx_sr_d = rx_sr_q;
    len_d   = len_q;
    ps_d    = ps_q;
    pha_d   = pha_q;
    pol_d   = pol_q;
    hold_d  = hold_q;
    cnt_d   = cnt_q;
    edge_d  = edge_q;
    clk_d   = clk_q;
    cs_d    = cs_q;
    abort_d = abort_q;
    done_d  = 1'b0;
    edge_ev = 1'b0;
    mif.b_en    = 1'b0;
    mif.b_we    = 1'b0;
    mif.b_addr  = {ptr_q, F_CTL};
    mif.b_wdata = '0;
    case (state_q)
      S_IDLE: begin
        clk_d = pol_q;
        if (group_trigger) begin
          ptr_d   = group_start;
          state_d = S_RD_CTL;
        end
      end
      S_RD_CTL: begin
        mif.b_en = 1'b1;
        state_d  = S_RD_TX;
      end
      S_RD_TX: begin
        mif.b_en   = 1'b1;
        mif.b_addr = {ptr_q, F_TX};
        ctl_d      = mif.b_rdata;
        state_d    = S_LOAD;
      end
      S_LOAD: begin
        len_d   = len_new;
        ps_d    = fmt[FMT_PS_LSB +: FMT_PS_W];
        pha_d   = fmt[FMT_PHA];
        pol_d   = fmt[FMT_POL];
        hold_d  = ctl_q[CTL_HOLD];
        tx_sr_d = mif.b_rdata << (5'h10 - len_new);
        rx_sr_d = '0;
        edge_d  = '0;
        abort_d = 1'b0;
        clk_d   = fmt[FMT_POL];
        cnt_d   = lead_len;
        cs_d    = ctrl;
        state_d = S_LEAD;
      end
      S_LEAD: begin
        if (ctrl) begin
          if (cnt_q == 10'h001) begin
            edge_ev = 1'b1;
          end else begin
            cnt_d = cnt_q - 10'h001;
          end
        end else if (cs_rise) begin
          state_d = S_SHIFT;
        end
      end
      S_SHIFT: begin
        if (ctrl) begin
          if (cnt_q == 10'h001) begin
            edge_ev = 1'b1;
          end else begin
            cnt_d = cnt_q - 10'h001;
          end
        end else if (!cs_act) begin
          abort_d = 1'b1;
          state_d = S_STORE;
        end else begin
          edge_ev = pin_edge;
        end
      end
      S_LAG: begin
        if (cnt_q == 10'h001) begin
          cs_d    = hold_q;
          state_d = S_STORE;
        end else begin
          cnt_d = cnt_q - 10'h001;
        end
      end
      S_STORE: begin
        mif.b_en    = 1'b1;
        mif.b_we    = 1'b1;
        mif.b_addr  = {ptr_q, F_RX};
        mif.b_wdata = rx_sr_q & rx_mask;
        state_d     = S_STAT;
      end
      S_STAT: begin
        mif.b_en    = 1'b1;
        mif.b_we    = 1'b1;
        mif.b_addr  = {ptr_q, F_STAT};
        mif.b_wdata = '0;
        mif.b_wdata[ST_DONE]  = 1'b1;
        mif.b_wdata[ST_ABORT] = abort_q;
        if (ptr_q == group_end) begin
          cs_d    = 1'b0;
          done_d  = 1'b1;
          state_d = S_IDLE;
        end else begin
          ptr_d   = ptr_q + 8'h01;
          state_d = S_RD_CTL;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    // One clock edge: toggle, sample on active edge, shift on the other, except the first edge when pha is 1
    if (edge_ev) begin
      edge_d  = edge_q + 6'h01;
      clk_d   = ~clk_q;
      cnt_d   = {1'b0, leading ? half_lo : half_hi};
      state_d = S_SHIFT;
      if (leading != pha_q) begin
        rx_sr_d = {rx_sr_q[DW-2:0], din};
      end
      if (pha_q ? (leading && edge_q != 6'h00) : !leading) begin
        tx_sr_d = {tx_sr_q[DW-2:0], 1'b0};
      end
      if (edge_d == edge_total) begin
        cnt_d   = lag_len;
        state_d = ctrl ? S_LAG : S_STORE;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      ptr_q   <= '0;
      ctl_q   <= '0;
      tx_sr_q <= '0;
      rx_sr_q <= '0;
      len_q   <= LEN_MAX;
      ps_q    <= '0;
      pha_q   <= 1'b0;
      pol_q   <= 1'b0;
      hold_q  <= 1'b0;
      cnt_q   <= '0;
      edge_q  <= '0;
      clk_q   <= 1'b0;
      cs_q    <= 1'b0;
      abort_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      ptr_q   <= ptr_d;
      ctl_q   <= ctl_d;
      tx_sr_q <= tx_sr_d;
      rx_sr_q <= rx_sr_d;
      len_q   <= len_d;
      ps_q    <= ps_d;
      pha_q   <= pha_d;
      pol_q   <= pol_d;
      hold_q  <= hold_d;
      cnt_q   <= cnt_d;
      edge_q  <= edge_d;
      clk_q   <= clk_d;
      cs_q    <= cs_d;
      abort_q <= abort_d;
      done_q  <= done_d;
    end
  end

  // ----------------------------------------
  // Pin drivers and status outputs
  // ----------------------------------------
  always_comb begin
    fn_o  = {~cs_q, tx_sr_q[DW-1], tx_sr_q[DW-1], clk_q};
    fn_oe = ctrl ? 4'hB : {1'b0, cs_act && state_q == S_SHIFT, 2'h0};
    for (int i = 0; i < PINS; i++) begin
      pin_o[i]  = gpio_sel[i] ? gpio_out[i] : fn_o[i];
      pin_oe[i] = gpio_sel[i] ? gpio_oe[i] : fn_oe[i];
    end
  end

  assign shift_clock_pin_o      = pin_o[PIN_CLK];
  assign shift_clock_pin_oe     = pin_oe[PIN_CLK];
  assign controller_out_line_o  = pin_o[PIN_SIMO];
  assign controller_out_line_oe = pin_oe[PIN_SIMO];
  assign controller_in_line_o   = pin_o[PIN_SOMI];
  assign controller_in_line_oe  = pin_oe[PIN_SOMI];
  assign chip_select_n_o        = pin_o[PIN_CS];
  assign chip_select_n_oe       = pin_oe[PIN_CS];
  assign busy                   = state_q != S_IDLE;
  assign group_done             = done_q;
  assign active_entry           = ptr_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [9:0] lead_obs_q, gap_q;
  logic [9:0] lead_exp_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lead_obs_q <= '0;
      lead_exp_q <= '0;
      gap_q      <= '0;
    end else begin
      lead_obs_q <= (state_q == S_LOAD) ? 10'h001 : lead_obs_q + 10'h001;
      lead_exp_q <= (state_q == S_LOAD) ? lead_len : lead_exp_q;
      gap_q      <= edge_ev ? 10'h001 : gap_q + 10'h001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_rx_write;
    mif.b_we && mif.b_addr == {ptr_q, F_RX};
  endsequence
  sequence s_stat_write;
    mif.b_we && mif.b_addr == {ptr_q, F_STAT} && mif.b_wdata[ST_DONE];
  endsequence

  a_lead_cycles: assert property (
    ctrl && state_q == S_LEAD && edge_ev |-> cs_q && lead_obs_q == lead_exp_q)
    else $error("select lead differs from programmed delay");
  a_half_period: assert property (
    ctrl && state_q == S_SHIFT && edge_ev |-> gap_q == {1'b0, leading ? half_hi : half_lo}
      && per_cur >= MIN_PERIOD_CYC)
    else $error("shift clock half period wrong");
  a_idle_level: assert property (
    ctrl && !cs_q && !gpio_sel[PIN_CLK] |-> shift_clock_pin_o == pol_q)
    else $error("shift clock not at idle level");
  a_cs_in_shift: assert property (
    ctrl && state_q == S_SHIFT |-> !chip_select_n_o || gpio_sel[PIN_CS])
    else $error("select dropped during shifting");
  a_word_edges: assert property (
    state_q == S_STORE && !abort_q |-> edge_q == edge_total && len_q >= LEN_MIN)
    else $error("word ended with wrong edge count");
  a_store_steps: assert property (
    state_q != S_STORE ##1 state_q == S_STORE |-> s_rx_write ##1 s_stat_write)
    else $error("receive or status word not stored");
  a_lag_release: assert property (
    ctrl && $rose(state_q == S_LAG) |-> (state_q == S_LAG)[*1] ##0
      (cnt_q == lag_len) ##[1:520] (state_q == S_STORE && cs_q == hold_q))
    else $error("select lag or hold wrong");
  a_mode_dir: assert property (
    !gpio_sel[PIN_CLK] |-> shift_clock_pin_oe == ctrl)
    else $error("shift clock direction does not follow mode");
  a_group_end: assert property (
    state_q == S_STAT && ptr_q == group_end |=> group_done && !busy)
    else $error("group did not finish at its last entry");
endmodule : msp_top

// ---- verilog/msp_pkg.sv ----
// Constants and types of the multibuffer serial port
package msp_pkg;
  // ----------------------------------------
  // Buffer geometry
  // ----------------------------------------
  localparam int DW        = 16;
  localparam int ENTRIES   = 256;
  localparam int ENTRY_AW  = 8;
  localparam int FIELDS    = 4;
  localparam int RAM_WORDS = ENTRIES * FIELDS;
  localparam int RAM_AW    = 10;
  localparam logic [1:0] F_TX   = 2'h0;
  localparam logic [1:0] F_RX   = 2'h1;
  localparam logic [1:0] F_CTL  = 2'h2;
  localparam logic [1:0] F_STAT = 2'h3;
  // ----------------------------------------
  // Register fields
  // ----------------------------------------
  localparam int GCR_CTRL    = 0;
  localparam int FMT_LEN_LSB = 0;
  localparam int FMT_LEN_W   = 5;
  localparam int FMT_PS_LSB  = 8;
  localparam int FMT_PS_W    = 8;
  localparam int FMT_PHA     = 16;
  localparam int FMT_POL     = 17;
  localparam int FMT_SETS    = 4;
  localparam int DLY_T2C_LSB = 0;
  localparam int DLY_C2T_LSB = 8;
  localparam int DLY_W       = 8;
  localparam int CTL_FSEL_LSB = 0;
  localparam int CTL_FSEL_W   = 2;
  localparam int CTL_HOLD     = 12;
  localparam int ST_DONE      = 0;
  localparam int ST_ABORT     = 1;
  localparam logic [4:0] LEN_MIN = 5'h02;
  localparam logic [4:0] LEN_MAX = 5'h10;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS        = 20;
  localparam int MIN_PERIOD_NS = 25;
  localparam logic [8:0] MIN_PERIOD_CYC = 9'((MIN_PERIOD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] PS0_PERIOD = 9'h002;
  localparam logic [9:0] C2T_BASE   = 10'h002;
  localparam logic [9:0] T2C_BASE   = 10'h001;
  localparam logic [9:0] HOLD_EXTRA = 10'h001;
  // ----------------------------------------
  // Pins
  // ----------------------------------------
  localparam int PINS     = 4;
  localparam int PIN_CLK  = 0;
  localparam int PIN_SIMO = 1;
  localparam int PIN_SOMI = 2;
  localparam int PIN_CS   = 3;
  localparam logic [3:0] PIN_IDLE = 4'h8;

  typedef enum logic [3:0] {
    S_IDLE, S_RD_CTL, S_RD_TX, S_LOAD, S_LEAD, S_SHIFT, S_LAG, S_STORE, S_STAT
  } msp_state_t;
endpackage : msp_pkg

// ---- verilog/msp_mem_if.sv ----
// Interface between the serial engine and its buffer memory
`timescale 1ns/1ps
interface msp_mem_if #(
  parameter int AW = 10,
  parameter int DW = 16
);
  logic          a_en;
  logic          a_we;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_wdata;
  logic [DW-1:0] a_rdata;
  logic          b_en;
  logic          b_we;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_wdata;
  logic [DW-1:0] b_rdata;
  modport mem  (input a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
                output a_rdata, b_rdata);
  modport user (output a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
                input a_rdata, b_rdata);
endinterface : msp_mem_if

// ---- verilog/msp_buf_ram.sv ----
// Two-port buffer memory with registered read data
`timescale 1ns/1ps
module msp_buf_ram
  import msp_pkg::*;
#(
  parameter int DEPTH = RAM_WORDS,
  parameter int WIDTH = DW
) (
  input wire logic clock,
  msp_mem_if.mem   m
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Port b writes last, so the engine wins a same-address collision
  always_ff @(posedge clock) begin
    if (m.a_en && m.a_we) begin
      mem_q[m.a_addr] <= m.a_wdata;
    end
    if (m.b_en && m.b_we) begin
      mem_q[m.b_addr] <= m.b_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (m.a_en) begin
      m.a_rdata <= mem_q[m.a_addr];
    end
  end

  always_ff @(posedge clock) begin
    if (m.b_en) begin
      m.b_rdata <= mem_q[m.b_addr];
    end
  end
endmodule : msp_buf_ram

// ---- dv/msp_peer_model.sv ----
// Far-side serial peripheral model and wire timing monitor
`timescale 1ns/1ps
module msp_peer_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  input  wire logic        pha,
  input  wire logic [31:0] reply,
  output logic             miso,
  output logic [31:0]      rx_bits,
  output logic [7:0]       n_edges,
  output logic [7:0]       n_frames,
  output logic [7:0]       lead,
  output logic [7:0]       lag,
  output logic [7:0]       hi_w,
  output logic [7:0]       lo_w
);
  logic [32:0] sh_q;
  logic [7:0]  cnt_q;
  logic        sclk_q;
  logic        cs_q;
  // Deselected, the line shows the inverse of its last level, never a stale bit
  assign miso = cs_n ? ~sh_q[32] : sh_q[32];
  // ----------------------------------------
  // Edge and width counting on clock samples
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_q <= '0;
      cnt_q <= '0;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      {rx_bits, n_edges, n_frames, lead, lag, hi_w, lo_w} <= '0;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      cnt_q <= cnt_q + 8'h01;
      if (cs_q && !cs_n) begin
        n_frames <= n_frames + 8'h01;
        n_edges <= 8'h00;
        cnt_q <= 8'h01;
        rx_bits <= '0;
        // Phase 1 shows its first bit only at the leading edge
        sh_q <= pha ? {1'b0, reply} : {reply, 1'b0};
      end else if (!cs_q && cs_n) begin
        lag <= cnt_q;
      end else if (!cs_n && sclk != sclk_q) begin
        cnt_q <= 8'h01;
        n_edges <= n_edges + 8'h01;
        if (n_edges == 8'h00) begin
          lead <= cnt_q;
        end else if (sclk_q) begin
          hi_w <= cnt_q;
        end else begin
          lo_w <= cnt_q;
        end
        if (n_edges[0] == pha) begin
          rx_bits <= {rx_bits[30:0], mosi};
        end else begin
          sh_q <= {sh_q[31:0], 1'b0};
        end
      end
    end
  end
endmodule : msp_peer_model

// ---- dv/msp_top_test.sv ----
// Self-checking bench of the multibuffer serial port
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module msp_top_test import msp_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [31:0] gcr = 32'h0000_0001;
  logic [FMT_SETS-1:0][31:0] fmt = {32'h0, 32'h0000_0702, 32'h0003_0710, 32'h0000_0708};
  logic [15:0] dly = 16'h0302;
  logic [7:0] g_start = 8'h00, g_end = 8'h00, act;
  logic trig = 1'b0, h_en = 1'b0, h_we = 1'b0, busy, done;
  logic [9:0] h_addr = 10'h000;
  logic [15:0] h_wd = 16'h0000, h_rd;
  logic sck_o, sck_oe, so_o, so_oe, si_o, si_oe, cs_o, cs_oe, miso, pha_m = 1'b0;
  logic [3:0] g_sel = 4'h0, g_out = 4'h0, g_oe = 4'h0, g_in;
  logic [31:0] reply = 32'h0, rx_bits;
  logic [7:0] n_edges, n_frames, lead, lag, hi_w, lo_w;
  int n_errors = 0, checked = 0, cycles = 0;
  // Far controller levels; idle they equal the board pulls (clock low, select and out high)
  logic ext_sck = 1'b0, ext_cs_n = 1'b1, ext_mosi = 1'b1;
  wire sck_w = sck_oe ? sck_o : ext_sck;
  wire cs_w = cs_oe ? cs_o : ext_cs_n;
  wire so_w = so_oe ? so_o : ext_mosi;
  wire si_w = si_oe ? si_o : miso;

  msp_top u_dut (.clock(clock), .rst(rst), .global_control_reg(gcr), .word_format_reg(fmt),
    .cs_delay_reg(dly), .group_start(g_start), .group_end(g_end), .group_trigger(trig),
    .busy(busy), .group_done(done), .active_entry(act), .host_en(h_en), .host_we(h_we),
    .host_addr(h_addr), .host_wdata(h_wd), .host_rdata(h_rd), .shift_clock_pin_i(sck_w),
    .shift_clock_pin_o(sck_o), .shift_clock_pin_oe(sck_oe), .controller_out_line_i(so_w),
    .controller_out_line_o(so_o), .controller_out_line_oe(so_oe),
    .controller_in_line_i(si_w), .controller_in_line_o(si_o), .controller_in_line_oe(si_oe),
    .chip_select_n_i(cs_w), .chip_select_n_o(cs_o), .chip_select_n_oe(cs_oe),
    .gpio_sel(g_sel), .gpio_out(g_out), .gpio_oe(g_oe), .gpio_in(g_in));
  msp_peer_model u_peer (.clock(clock), .rst(rst), .sclk(sck_w), .cs_n(cs_w), .mosi(so_w),
    .pha(pha_m), .reply(reply), .miso(miso), .rx_bits(rx_bits), .n_edges(n_edges),
    .n_frames(n_frames), .lead(lead), .lag(lag), .hi_w(hi_w), .lo_w(lo_w));

  always #10 clock = ~clock;
  // ----------------------------------------
  // Bus and run helpers
  // ----------------------------------------
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    h_en = 1'b1;
    h_we = 1'b1;
    h_addr = a;
    h_wd = d;
    @(posedge clock) #1;
    h_en = 1'b0;
    h_we = 1'b0;
    // Idle edge, so a following write never re-raises the strobe in the same step
    @(posedge clock) #1;
  endtask : wr
  task automatic chk_ram(input logic [7:0] e, input logic [1:0] f, input logic [15:0] exp);
    h_en = 1'b1;
    h_addr = {e, f};
    @(posedge clock) #1;
    h_en = 1'b0;
    @(posedge clock) #1;
    `CHK(h_rd, exp)
  endtask : chk_ram
  task automatic load(input logic [7:0] e, input logic [15:0] ctl, input logic [15:0] tx);
    wr({e, F_TX}, tx);
    wr({e, F_CTL}, ctl);
  endtask : load
  task automatic run(input logic [7:0] s, input logic [7:0] e);
    g_start = s;
    g_end = e;
    trig = 1'b1;
    @(posedge clock) #1;
    trig = 1'b0;
    for (int i = 0; i < 3000 && done !== 1'b1; i++) @(posedge clock) #1;
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
  endtask : run
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_basic;
    pha_m = 1'b0;
    reply = 32'h96F0_0000;
    // Word sits in the low length bits; the upper bits must never go out
    load(8'h00, 16'h0000, 16'hC3A5);
    run(8'h00, 8'h00);
    `CHK(rx_bits[7:0], 8'hA5)
    `CHK(n_edges, 8'h10)
    `CHK(lead, 8'h05)
    `CHK(lag, 8'h07)
    `CHK(hi_w, 8'h04)
    `CHK(lo_w, 8'h04)
    chk_ram(8'h00, F_RX, 16'h0096);
    chk_ram(8'h00, F_STAT, 16'(1 << ST_DONE));
    $display("test basic done");
  endtask : t_basic
  task automatic t_hold;
    reply = 32'hE1C0_0000;
    load(8'hFE, 16'h1000, 16'hFF5A);
    load(8'hFF, 16'h0002, 16'hFFC3);
    run(8'hFE, 8'hFF);
    `CHK(act, 8'hFF)
    `CHK(n_frames, 8'h02)
    `CHK(n_edges, 8'h14)
    `CHK(lead, 8'h06)
    `CHK(lag, 8'h07)
    `CHK(rx_bits[9:0], 10'h16B)
    chk_ram(8'hFE, F_RX, 16'h00E1);
    chk_ram(8'hFF, F_RX, 16'h0003);
    chk_ram(8'hFF, F_STAT, 16'(1 << ST_DONE));
    $display("test hold done");
  endtask : t_hold
  task automatic t_pha1;
    pha_m = 1'b1;
    reply = 32'h1234_0000;
    load(8'h03, 16'h0001, 16'hBEEF);
    run(8'h03, 8'h03);
    `CHK(n_frames, 8'h03)
    `CHK(lead, 8'h09)
    `CHK(lag, 8'h03)
    `CHK(rx_bits[15:0], 16'hBEEF)
    `CHK(sck_w, 1'b1)
    chk_ram(8'h03, F_RX, 16'h1234);
    $display("test phase one done");
  endtask : t_pha1
  task automatic t_gpio;
    g_sel = 4'h1;
    g_out = 4'h1;
    g_oe = 4'h1;
    repeat (4) @(posedge clock) #1;
    `CHK({sck_oe, sck_o}, 2'h3)
    `CHK(g_in[0], 1'b1)
    g_out = 4'h0;
    repeat (4) @(posedge clock) #1;
    `CHK(g_in[0], 1'b0)
    g_sel = 4'h0;
    $display("test gpio done");
  endtask : t_gpio
  task automatic tgt_go(input logic [7:0] e);
    g_start = e;
    g_end = e;
    trig = 1'b1;
    @(posedge clock) #1;
    trig = 1'b0;
    repeat (4) @(posedge clock) #1;
    ext_cs_n = 1'b0;
    repeat (16) @(posedge clock) #1;
  endtask : tgt_go
  task automatic tgt_end;
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge clock) #1;
    `CHK(done, 1'b1)
    ext_cs_n = 1'b1;
    ext_sck = 1'b0;
    ext_mosi = 1'b1;
  endtask : tgt_end
  task automatic t_target;
    logic [7:0] pat, got;
    pat = 8'h96;
    got = 8'h00;
    gcr = 32'h0000_0000;
    load(8'h10, 16'h0000, 16'hC33C);
    load(8'h11, 16'h0000, 16'h0000);
    `CHK({sck_oe, cs_oe, so_oe}, 3'h0)
    tgt_go(8'h10);
    for (int i = 0; i < 8; i++) begin
      ext_mosi = pat[7 - i];
      repeat (4) @(posedge clock) #1;
      got = {got[6:0], si_w};
      ext_sck = 1'b1;
      repeat (4) @(posedge clock) #1;
      ext_sck = 1'b0;
    end
    tgt_end();
    `CHK(got, 8'h3C)
    chk_ram(8'h10, F_RX, 16'h0096);
    // Select released after one clock edge: the word must be marked aborted
    tgt_go(8'h11);
    ext_sck = 1'b1;
    repeat (4) @(posedge clock) #1;
    ext_cs_n = 1'b1;
    tgt_end();
    chk_ram(8'h11, F_STAT, 16'h0003);
    $display("test target done");
  endtask : t_target

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // Whole run needs well under 3000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, cycles, 0);
      end_sim();
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    @(posedge clock) #1;
    `CHK({sck_oe, cs_oe, cs_o}, 3'h7)
    t_basic();
    t_hold();
    t_pha1();
    t_gpio();
    t_target();
    end_sim();
  end
endmodule : msp_top_test
